// [fcx_exec_core.sv]
`timescale 1ns/1ps

// Overview of operation
// RL1 - Return pops flags, then program counter.
// RL2 - Load flags from immediate, register or memory.
// RL3 - Post-increment load adds two to pointer.
// RL4 - Store flags to register or memory, unchanged.
// RL5 - Pre-decrement store subtracts two, then writes.
// RL6 - Flag AND with immediate.
// RL7 - Flag OR with immediate.
// RL8 - Flag XOR with immediate.
// RL9 - Copy moves one byte, bumps both pointers.
// RL10 - Byte count decrements, stops at zero.
// RL11 - Word count decrements, stops at zero.
// RL12 - Zero count copies nothing.
// RL13 - Copy takes eight plus four per byte.
// RL14 - State counts assume on-chip memory.
// RL15 - Half-carry from bit eleven or twenty-seven.
// RL16 - Sticky zero keeps or clears zero flag.
// RL17 - Decimal adjust carry sets or keeps.
// RL18 - Divide flags from divisor and quotient signs.
// RL19 - Synchronised transfers take variable states.
// RL20 - Power-down halts fetch until wake-up.
// RL21 - No-operation only advances counter by two.
module fcx_exec_core (
	input  wire logic              sys_clk,
	input  wire logic              rst,
	input  wire logic              op_valid,
	input  wire fcx_pkg::fcx_op_t  op_code,
	input  wire fcx_pkg::fcx_mode_t op_mode,
	input  wire logic [7:0]        op_imm,
	input  wire logic [7:0]        op_reg_byte,
	input  wire logic [31:0]       op_ptr,
	input  wire logic [23:0]       op_disp,
	input  wire logic [23:0]       op_abs,
	input  wire logic [23:0]       op_len,
	input  wire logic [15:0]       copy_count_word,
	input  wire logic [15:0]       copy_source_ptr,
	input  wire logic [15:0]       copy_dest_ptr,
	input  wire logic              sp_load,
	input  wire logic [31:0]       sp_value,
	input  wire logic              fl_valid,
	input  wire fcx_pkg::fcx_fk_t  fl_kind,
	input  wire logic [31:0]       fl_a,
	input  wire logic [31:0]       fl_b,
	input  wire logic              fl_sub,
	input  wire logic              fl_res_zero,
	input  wire logic              fl_adj_carry,
	input  wire logic              fl_divisor_neg,
	input  wire logic              fl_divisor_zero,
	input  wire logic              fl_quot_neg,
	input  wire logic              wake_pin,
	input  wire logic              mem_ack,
	input  wire logic [15:0]       mem_rdata,
	output logic                   op_ready,
	output logic                   op_done,
	output logic [7:0]             flag_register,
	output logic [23:0]            pc_out,
	output logic [31:0]            stack_pointer,
	output logic                   reg_byte_we,
	output logic [7:0]             reg_byte_out,
	output logic                   wide_ptr_we,
	output logic [31:0]            wide_ptr_out,
	output logic                   copy_wb,
	output logic [15:0]            copy_count_out,
	output logic [15:0]            copy_src_out,
	output logic [15:0]            copy_dst_out,
	output logic                   power_down,
	output logic                   mem_req,
	output logic                   mem_we,
	output logic                   mem_byte,
	output logic [23:0]            mem_addr,
	output logic [15:0]            mem_wdata
);

	typedef enum logic [3:0] {
		ST_IDLE, ST_EXEC, ST_MEM_RD, ST_MEM_WR, ST_POP_FLAG, ST_POP_PC,
		ST_SLEEP_ENT, ST_SLEEP, ST_CP_SETUP, ST_CP_RD, ST_CP_WR
	} fcx_state_t;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic [23:0] fcx_ea(input fcx_pkg::fcx_mode_t m,
		input logic [31:0] p, input logic [23:0] d, input logic [23:0] a,
		input logic is_store);
		case (m)
			fcx_pkg::MODE_DISP: fcx_ea = p[23:0] + d;
			fcx_pkg::MODE_AUTO: fcx_ea = is_store ? p[23:0] - fcx_pkg::PTR_STEP[23:0]
			                                      : p[23:0];
			fcx_pkg::MODE_ABS:  fcx_ea = a;
			default:            fcx_ea = p[23:0];
		endcase
	endfunction

	function automatic logic fcx_is_mem(input fcx_pkg::fcx_mode_t m);
		fcx_is_mem = (m != fcx_pkg::MODE_IMM) && (m != fcx_pkg::MODE_REG);
	endfunction

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	fcx_state_t         state_ff, nxt_state;
	fcx_pkg::fcx_op_t   opc_ff, nxt_opc;
	fcx_pkg::fcx_mode_t mode_ff, nxt_mode;
	logic [7:0]  opnd_ff, nxt_opnd;
	logic [31:0] ptr_ff, nxt_ptr;
	logic [23:0] len_ff, nxt_len;
	logic [3:0]  timer_ff, nxt_timer;
	logic [7:0]  data_ff, nxt_data;
	logic        ready_ff, nxt_ready, done_ff, nxt_done;
	logic [7:0]  flags_ff, nxt_flags;
	logic [23:0] pc_ff, nxt_pc;
	logic [31:0] sp_ff, nxt_sp;
	logic        r8we_ff, nxt_r8we, pwe_ff, nxt_pwe, cwb_ff, nxt_cwb, pd_ff, nxt_pd;
	logic [7:0]  r8_ff, nxt_r8;
	logic [31:0] pwb_ff, nxt_pwb;
	logic [15:0] cnt_ff, nxt_cnt, src_ff, nxt_src, dst_ff, nxt_dst;
	logic        req_ff, nxt_req, we_ff, nxt_we, byte_ff, nxt_byte;
	logic [23:0] addr_ff, nxt_addr;
	logic [15:0] wdata_ff, nxt_wdata;
	logic        wake_meta_ff, wake_sync_ff;
	logic [7:0]  fl_flags;

	fcx_flag_unit u_flag_unit (
		.flags_in     (flags_ff),
		.kind         (fl_kind),
		.opnd_a       (fl_a),
		.opnd_b       (fl_b),
		.subtract     (fl_sub),
		.res_zero     (fl_res_zero),
		.adj_carry    (fl_adj_carry),
		.divisor_neg  (fl_divisor_neg),
		.divisor_zero (fl_divisor_zero),
		.quot_neg     (fl_quot_neg),
		.flags_out    (fl_flags)
	);

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;  nxt_opc = opc_ff;    nxt_mode = mode_ff;
		nxt_opnd  = opnd_ff;   nxt_ptr = ptr_ff;    nxt_len = len_ff;
		nxt_timer = timer_ff;  nxt_data = data_ff;  nxt_ready = ready_ff;
		nxt_done  = 1'b0;      nxt_flags = flags_ff; nxt_pc = pc_ff;
		nxt_sp    = sp_ff;     nxt_r8we = 1'b0;     nxt_pwe = 1'b0;
		nxt_cwb   = 1'b0;      nxt_pd = pd_ff;      nxt_r8 = r8_ff;
		nxt_pwb   = pwb_ff;    nxt_cnt = cnt_ff;    nxt_src = src_ff;
		nxt_dst   = dst_ff;    nxt_req = req_ff;    nxt_we = we_ff;
		nxt_byte  = byte_ff;   nxt_addr = addr_ff;  nxt_wdata = wdata_ff;
		case (state_ff)
			ST_IDLE: begin
				if (sp_load) begin
					nxt_sp = sp_value;
				end
				if (op_valid) begin
					nxt_ready = 1'b0;
					nxt_opc   = op_code;
					nxt_mode  = op_mode;
					nxt_opnd  = (op_mode == fcx_pkg::MODE_REG) ? op_reg_byte : op_imm;
					nxt_ptr   = op_ptr;
					nxt_len   = op_len;
					nxt_state = ST_EXEC;
					case (op_code)
						fcx_pkg::OP_POWER_DOWN: nxt_state = ST_SLEEP_ENT; // [RL20]
						fcx_pkg::OP_EXCEPTION_RETURN: begin
							nxt_state = ST_POP_FLAG; // [RL1]
							nxt_req   = 1'b1;
							nxt_we    = 1'b0;
							nxt_byte  = 1'b0;
							nxt_addr  = sp_ff[23:0];
						end
						fcx_pkg::OP_LOAD_FLAGS, fcx_pkg::OP_STORE_FLAGS: begin
							if (fcx_is_mem(op_mode)) begin
								nxt_state = (op_code == fcx_pkg::OP_STORE_FLAGS) ? ST_MEM_WR
								                                                 : ST_MEM_RD;
								nxt_req   = 1'b1;
								nxt_we    = (op_code == fcx_pkg::OP_STORE_FLAGS);
								nxt_byte  = 1'b0;
								nxt_addr  = fcx_ea(op_mode, op_ptr, op_disp, op_abs,
								                   op_code == fcx_pkg::OP_STORE_FLAGS); // [RL5]
								nxt_wdata = {flags_ff, flags_ff}; // [RL4]
							end
						end
						fcx_pkg::OP_BLOCK_COPY_BYTE, fcx_pkg::OP_BLOCK_COPY_WORD: begin
							nxt_state = ST_CP_SETUP;
							nxt_timer = fcx_pkg::COPY_SETUP_CYC; // [RL13] [RL14]
							nxt_cnt   = (op_code == fcx_pkg::OP_BLOCK_COPY_BYTE)
							          ? {8'h00, copy_count_word[7:0]} // [RL10]
							          : copy_count_word;              // [RL11]
							nxt_src   = copy_source_ptr;
							nxt_dst   = copy_dest_ptr;
						end
						default: nxt_state = ST_EXEC;
					endcase
				end else if (fl_valid) begin
					nxt_flags = fl_flags; // [RL15] [RL16] [RL17] [RL18]
				end
			end
			ST_EXEC: begin
				case (opc_ff)
					fcx_pkg::OP_LOAD_FLAGS:   nxt_flags = opnd_ff;            // [RL2]
					fcx_pkg::OP_FLAG_AND_IMM: nxt_flags = flags_ff & opnd_ff; // [RL6]
					fcx_pkg::OP_FLAG_OR_IMM:  nxt_flags = flags_ff | opnd_ff; // [RL7]
					fcx_pkg::OP_FLAG_XOR_IMM: nxt_flags = flags_ff ^ opnd_ff; // [RL8]
					fcx_pkg::OP_STORE_FLAGS: begin
						nxt_r8we = 1'b1; // [RL4]
						nxt_r8   = flags_ff;
					end
					default: nxt_flags = flags_ff;
				endcase
				nxt_pc    = (opc_ff == fcx_pkg::OP_NO_OPERATION) ? pc_ff + fcx_pkg::PC_STEP
				                                                 : pc_ff + len_ff; // [RL21]
				nxt_done  = 1'b1;
				nxt_ready = 1'b1;
				nxt_state = ST_IDLE;
			end
			ST_MEM_RD, ST_MEM_WR: begin
				// Wait states stretch here for slow or synchronised memory.
				if (mem_ack) begin // [RL19]
					nxt_req = 1'b0;
					if (state_ff == ST_MEM_RD) begin
						nxt_flags = mem_rdata[7:0]; // [RL2]
						nxt_pwb   = ptr_ff + fcx_pkg::PTR_STEP; // [RL3]
					end else begin
						nxt_pwb   = ptr_ff - fcx_pkg::PTR_STEP; // [RL5]
					end
					nxt_pwe   = (mode_ff == fcx_pkg::MODE_AUTO);
					nxt_pc    = pc_ff + len_ff;
					nxt_done  = 1'b1;
					nxt_ready = 1'b1;
					nxt_state = ST_IDLE;
				end
			end
			ST_POP_FLAG: begin
				if (mem_ack) begin
					nxt_flags = mem_rdata[7:0]; // [RL1]
					nxt_sp    = sp_ff + fcx_pkg::STACK_STEP;
					nxt_addr  = nxt_sp[23:0];
					nxt_state = ST_POP_PC;
				end
			end
			ST_POP_PC: begin
				if (mem_ack) begin
					nxt_pc    = {8'h00, mem_rdata}; // [RL1]
					nxt_sp    = sp_ff + fcx_pkg::STACK_STEP;
					nxt_req   = 1'b0;
					nxt_done  = 1'b1;
					nxt_ready = 1'b1;
					nxt_state = ST_IDLE;
				end
			end
			ST_SLEEP_ENT: begin
				nxt_pd    = 1'b1; // [RL20]
				nxt_state = ST_SLEEP;
			end
			ST_SLEEP: begin
				if (wake_sync_ff) begin
					nxt_pd    = 1'b0;
					nxt_pc    = pc_ff + len_ff;
					nxt_done  = 1'b1;
					nxt_ready = 1'b1;
					nxt_state = ST_IDLE;
				end
			end
			ST_CP_SETUP: begin
				if (timer_ff > 4'h1) begin
					nxt_timer = timer_ff - 4'h1;
				end else if (cnt_ff == 16'h0000) begin
					nxt_cwb   = 1'b1; // [RL12]
					nxt_pc    = pc_ff + len_ff;
					nxt_done  = 1'b1;
					nxt_ready = 1'b1;
					nxt_state = ST_IDLE;
				end else begin
					nxt_req   = 1'b1;
					nxt_we    = 1'b0;
					nxt_byte  = 1'b1;
					nxt_addr  = {8'h00, src_ff}; // [RL9]
					nxt_state = ST_CP_RD;
				end
			end
			ST_CP_RD: begin
				if (mem_ack) begin
					nxt_data  = mem_rdata[7:0];
					nxt_we    = 1'b1;
					nxt_addr  = {8'h00, dst_ff}; // [RL9]
					nxt_wdata = {8'h00, mem_rdata[7:0]};
					nxt_state = ST_CP_WR;
				end
			end
			ST_CP_WR: begin
				if (mem_ack) begin
					nxt_src = src_ff + fcx_pkg::COPY_STEP; // [RL9]
					nxt_dst = dst_ff + fcx_pkg::COPY_STEP; // [RL9]
					nxt_cnt = cnt_ff - fcx_pkg::COPY_STEP; // [RL10] [RL11]
					nxt_we  = 1'b0;
					if (cnt_ff == fcx_pkg::COPY_STEP) begin
						nxt_req   = 1'b0;
						nxt_cwb   = 1'b1;
						nxt_pc    = pc_ff + len_ff;
						nxt_done  = 1'b1;
						nxt_ready = 1'b1;
						nxt_state = ST_IDLE;
					end else begin
						nxt_addr  = {8'h00, nxt_src};
						nxt_state = ST_CP_RD;
					end
				end
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_ff <= ST_IDLE;  opc_ff <= fcx_pkg::OP_NO_OPERATION;
			mode_ff <= fcx_pkg::MODE_IMM; opnd_ff <= 8'h00; ptr_ff <= 32'h0000_0000;
			len_ff <= 24'h00_0000; timer_ff <= 4'h0; data_ff <= 8'h00;
			ready_ff <= 1'b1; done_ff <= 1'b0; flags_ff <= fcx_pkg::FLAG_RESET;
			pc_ff <= fcx_pkg::PC_RESET; sp_ff <= fcx_pkg::SP_RESET;
			r8we_ff <= 1'b0; pwe_ff <= 1'b0; cwb_ff <= 1'b0; pd_ff <= 1'b0;
			r8_ff <= 8'h00; pwb_ff <= 32'h0000_0000; cnt_ff <= 16'h0000;
			src_ff <= 16'h0000; dst_ff <= 16'h0000; req_ff <= 1'b0; we_ff <= 1'b0;
			byte_ff <= 1'b0; addr_ff <= 24'h00_0000; wdata_ff <= 16'h0000;
			wake_meta_ff <= 1'b0; wake_sync_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state; opc_ff <= nxt_opc; mode_ff <= nxt_mode;
			opnd_ff <= nxt_opnd; ptr_ff <= nxt_ptr; len_ff <= nxt_len;
			timer_ff <= nxt_timer; data_ff <= nxt_data; ready_ff <= nxt_ready;
			done_ff <= nxt_done; flags_ff <= nxt_flags; pc_ff <= nxt_pc;
			sp_ff <= nxt_sp; r8we_ff <= nxt_r8we; pwe_ff <= nxt_pwe;
			cwb_ff <= nxt_cwb; pd_ff <= nxt_pd; r8_ff <= nxt_r8; pwb_ff <= nxt_pwb;
			cnt_ff <= nxt_cnt; src_ff <= nxt_src; dst_ff <= nxt_dst;
			req_ff <= nxt_req; we_ff <= nxt_we; byte_ff <= nxt_byte;
			addr_ff <= nxt_addr; wdata_ff <= nxt_wdata;
			wake_meta_ff <= wake_pin;
			wake_sync_ff <= wake_meta_ff;
		end
	end

	assign op_ready = ready_ff;       assign op_done = done_ff;
	assign flag_register = flags_ff;  assign pc_out = pc_ff;
	assign stack_pointer = sp_ff;     assign reg_byte_we = r8we_ff;
	assign reg_byte_out = r8_ff;      assign wide_ptr_we = pwe_ff;
	assign wide_ptr_out = pwb_ff;     assign copy_wb = cwb_ff;
	assign copy_count_out = cnt_ff;   assign copy_src_out = src_ff;
	assign copy_dst_out = dst_ff;     assign power_down = pd_ff;
	assign mem_req = req_ff;          assign mem_we = we_ff;
	assign mem_byte = byte_ff;        assign mem_addr = addr_ff;
	assign mem_wdata = wdata_ff;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	// Cycles since a copy was accepted, its count and the cycles spent waiting on memory.
	logic [19:0] cp_cyc_ff;
	logic [19:0] cp_wait_ff;
	logic [15:0] cp_n_ff;
	logic        cp_acc;
	assign cp_acc = state_ff == ST_IDLE && op_valid &&
		(op_code == fcx_pkg::OP_BLOCK_COPY_BYTE || op_code == fcx_pkg::OP_BLOCK_COPY_WORD);
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cp_cyc_ff  <= 20'h00000;
			cp_wait_ff <= 20'h00000;
			cp_n_ff    <= 16'h0000;
		end else if (cp_acc) begin
			cp_cyc_ff  <= 20'h00001;
			cp_wait_ff <= 20'h00000;
			cp_n_ff    <= nxt_cnt;
		end else begin
			cp_cyc_ff <= cp_cyc_ff + 20'h00001;
			if ((state_ff == ST_CP_RD || state_ff == ST_CP_WR) && !mem_ack) begin
				cp_wait_ff <= cp_wait_ff + 20'h00001;
			end
		end
	end

	sequence pop_flag_done_s;
		state_ff == ST_POP_FLAG && mem_ack;
	endsequence
	sequence pop_pc_issue_s;
		state_ff == ST_POP_PC && mem_req && addr_ff == $past(sp_ff[23:0]) + 24'h00_0002;
	endsequence

	ret_pop_order_a: assert property (pop_flag_done_s |=> pop_pc_issue_s) // [RL1]
		else $error("program counter pop did not follow flag pop");
	load_flags_a: assert property (state_ff == ST_EXEC && opc_ff == fcx_pkg::OP_LOAD_FLAGS
		|=> flags_ff == $past(opnd_ff)) // [RL2]
		else $error("load flags did not take the operand");
	post_inc_a: assert property (state_ff == ST_MEM_RD && mem_ack && mode_ff == fcx_pkg::MODE_AUTO
		|=> wide_ptr_we && wide_ptr_out == $past(ptr_ff) + 32'h0000_0002) // [RL3]
		else $error("post-increment pointer wrong");
	store_keep_a: assert property (state_ff == ST_MEM_WR |=> $stable(flags_ff)) // [RL4]
		else $error("store flags altered the flags");
	pre_dec_a: assert property (state_ff == ST_IDLE && op_valid && op_code == fcx_pkg::OP_STORE_FLAGS
		&& op_mode == fcx_pkg::MODE_AUTO |=> mem_we && mem_addr == $past(op_ptr[23:0]) - 24'h00_0002) // [RL5]
		else $error("pre-decrement address wrong");
	flag_and_a: assert property (state_ff == ST_EXEC && opc_ff == fcx_pkg::OP_FLAG_AND_IMM
		|=> flags_ff == ($past(flags_ff) & $past(opnd_ff))) // [RL6]
		else $error("flag AND result wrong");
	flag_or_a: assert property (state_ff == ST_EXEC && opc_ff == fcx_pkg::OP_FLAG_OR_IMM
		|=> flags_ff == ($past(flags_ff) | $past(opnd_ff))) // [RL7]
		else $error("flag OR result wrong");
	flag_xor_a: assert property (state_ff == ST_EXEC && opc_ff == fcx_pkg::OP_FLAG_XOR_IMM
		|=> flags_ff == ($past(flags_ff) ^ $past(opnd_ff))) // [RL8]
		else $error("flag XOR result wrong");
	copy_step_a: assert property (state_ff == ST_CP_WR && mem_ack
		|=> src_ff == $past(src_ff) + 16'h0001 && dst_ff == $past(dst_ff) + 16'h0001
		&& cnt_ff == $past(cnt_ff) - 16'h0001) // [RL9] [RL10] [RL11]
		else $error("copy pointers or count not stepped");
	copy_zero_a: assert property (cp_acc && nxt_cnt == 16'h0000
		|=> !mem_req [*7] ##1 op_done) // [RL12]
		else $error("zero-count copy did not end cleanly");
	copy_time_a: assert property ($rose(copy_wb) // [RL13] [RL14] [RL19]
		|-> cp_cyc_ff == 20'(fcx_pkg::COPY_BASE_ST) + 20'(fcx_pkg::COPY_BYTE_ST) * {4'h0, cp_n_ff}
		+ cp_wait_ff - {3'h0, cp_n_ff, 1'b0})
		else $error("copy took the wrong number of cycles");
	sleep_entry_a: assert property (state_ff == ST_IDLE && op_valid
		&& op_code == fcx_pkg::OP_POWER_DOWN |=> ##1 power_down && !op_ready) // [RL20]
		else $error("power-down not entered in two cycles");
	nop_step_a: assert property (state_ff == ST_EXEC && opc_ff == fcx_pkg::OP_NO_OPERATION
		|=> pc_ff == $past(pc_ff) + 24'h00_0002 && $stable(flags_ff)) // [RL21]
		else $error("no-operation did not only step the counter");

endmodule

// [fcx_pkg.sv]
package fcx_pkg;

	// ------------------------------------------------------------------
	// Flag register layout and reset value
	// ------------------------------------------------------------------
	localparam int unsigned FLAG_BIT_H = 5;
	localparam int unsigned FLAG_BIT_N = 3;
	localparam int unsigned FLAG_BIT_Z = 2;
	localparam int unsigned FLAG_BIT_V = 1;
	localparam int unsigned FLAG_BIT_C = 0;
	localparam logic [7:0]  FLAG_RESET = 8'h80;

	// ------------------------------------------------------------------
	// Arithmetic and timing constants
	// ------------------------------------------------------------------
	localparam int unsigned HALF_BIT_WORD  = 11;
	localparam int unsigned HALF_BIT_LONG  = 27;
	localparam logic [31:0] PTR_STEP       = 32'h0000_0002;
	localparam logic [31:0] STACK_STEP     = 32'h0000_0002;
	localparam logic [23:0] PC_STEP        = 24'h00_0002;
	localparam logic [15:0] COPY_STEP      = 16'h0001;
	localparam int unsigned COPY_BASE_ST   = 8;
	localparam int unsigned COPY_BYTE_ST   = 4;
	localparam logic [3:0]  COPY_SETUP_CYC = 4'(COPY_BASE_ST - 1);
	localparam int unsigned SLEEP_ENTRY_ST = 2;
	localparam logic [31:0] SP_RESET       = 32'h0000_0000;
	localparam logic [23:0] PC_RESET       = 24'h00_0000;

	// ------------------------------------------------------------------
	// Operations, operand modes and flag update kinds
	// ------------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_NO_OPERATION, OP_POWER_DOWN, OP_EXCEPTION_RETURN, OP_LOAD_FLAGS,
		OP_STORE_FLAGS, OP_FLAG_AND_IMM, OP_FLAG_OR_IMM, OP_FLAG_XOR_IMM,
		OP_BLOCK_COPY_BYTE, OP_BLOCK_COPY_WORD
	} fcx_op_t;

	typedef enum logic [2:0] {
		MODE_IMM, MODE_REG, MODE_IND, MODE_DISP, MODE_AUTO, MODE_ABS
	} fcx_mode_t;

	typedef enum logic [2:0] {
		FK_HALF_WORD, FK_HALF_LONG, FK_STICKY_ZERO, FK_DEC_ADJUST, FK_DIVIDE
	} fcx_fk_t;

endpackage

// [fcx_flag_unit.sv]
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Flag update helper for the arithmetic footnote cases
// ----------------------------------------------------------------------
module fcx_flag_unit (
	input  wire logic [7:0]      flags_in,
	input  wire fcx_pkg::fcx_fk_t kind,
	input  wire logic [31:0]     opnd_a,
	input  wire logic [31:0]     opnd_b,
	input  wire logic            subtract,
	input  wire logic            res_zero,
	input  wire logic            adj_carry,
	input  wire logic            divisor_neg,
	input  wire logic            divisor_zero,
	input  wire logic            quot_neg,
	output logic [7:0]           flags_out
);

	logic [12:0] half_w;
	logic [28:0] half_l;

	always_comb begin
		half_w = subtract ? {1'b0, opnd_a[11:0]} - {1'b0, opnd_b[11:0]}
		                  : {1'b0, opnd_a[11:0]} + {1'b0, opnd_b[11:0]};
		half_l = subtract ? {1'b0, opnd_a[27:0]} - {1'b0, opnd_b[27:0]}
		                  : {1'b0, opnd_a[27:0]} + {1'b0, opnd_b[27:0]};
		flags_out = flags_in;
		case (kind)
			fcx_pkg::FK_HALF_WORD: begin
				flags_out[fcx_pkg::FLAG_BIT_H] = half_w[fcx_pkg::HALF_BIT_WORD + 1]; // [RL15]
			end
			fcx_pkg::FK_HALF_LONG: begin
				flags_out[fcx_pkg::FLAG_BIT_H] = half_l[fcx_pkg::HALF_BIT_LONG + 1]; // [RL15]
			end
			fcx_pkg::FK_STICKY_ZERO: begin
				if (!res_zero) begin
					flags_out[fcx_pkg::FLAG_BIT_Z] = 1'b0; // [RL16]
				end
			end
			fcx_pkg::FK_DEC_ADJUST: begin
				if (adj_carry) begin
					flags_out[fcx_pkg::FLAG_BIT_C] = 1'b1; // [RL17]
				end
			end
			fcx_pkg::FK_DIVIDE: begin
				flags_out[fcx_pkg::FLAG_BIT_N] = quot_neg;     // [RL18]
				flags_out[fcx_pkg::FLAG_BIT_Z] = divisor_zero; // [RL18]
				flags_out[fcx_pkg::FLAG_BIT_V] = divisor_neg;  // [RL18]
			end
			default: begin
				flags_out = flags_in;
			end
		endcase
	end

endmodule

// [fcx_mem_model.sv]
`timescale 1ns/1ps

module fcx_mem_model (
	input  wire logic        sys_clk,
	input  wire logic        mem_req,
	input  wire logic        mem_we,
	input  wire logic        mem_byte,
	input  wire logic [23:0] mem_addr,
	input  wire logic [15:0] mem_wdata,
	input  wire logic [3:0]  ack_dly,
	output logic             mem_ack,
	output logic [15:0]      mem_rdata
);
	logic [7:0] mem [0:255];
	logic [3:0] wait_ff = 4'h0;
	logic [7:0] a;

	assign a = mem_addr[7:0];
	initial mem_ack = 1'b0;
	initial mem_rdata = 16'h0000;

	// Idle read data toggles so a stale capture never looks right.
	always @(posedge sys_clk) begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (mem_req && !mem_ack && wait_ff == ack_dly) begin
			wait_ff <= 4'h0;
			mem_ack <= 1'b1;
			if (mem_we && mem_byte)
				mem[a] <= mem_wdata[7:0];
			else if (mem_we) begin
				mem[a] <= mem_wdata[15:8];
				mem[a + 8'h01] <= mem_wdata[7:0];
			end
			mem_rdata <= mem_byte ? {~mem[a], mem[a]} : {mem[a], mem[a + 8'h01]};
		end else if (mem_req && !mem_ack)
			wait_ff <= wait_ff + 4'h1;
	end
endmodule

// [flag_and_block_copy_exec_test.sv]
`timescale 1ns/1ps

module flag_and_block_copy_exec_test;
	logic sys_clk = 1'b0, rst = 1'b1, op_valid = 1'b0, sp_load = 1'b0, fl_valid = 1'b0;
	logic fl_sub = 1'b0, fl_res_zero = 1'b0, fl_adj_carry = 1'b0, wake_pin = 1'b0;
	logic fl_divisor_neg = 1'b0, fl_divisor_zero = 1'b0, fl_quot_neg = 1'b0;
	fcx_pkg::fcx_op_t   op_code = fcx_pkg::OP_NO_OPERATION;
	fcx_pkg::fcx_mode_t op_mode = fcx_pkg::MODE_IMM;
	fcx_pkg::fcx_fk_t   fl_kind = fcx_pkg::FK_STICKY_ZERO;
	logic [7:0]  op_imm = 8'h00, op_reg_byte = 8'h00, f;
	logic [31:0] op_ptr = 32'h0, sp_value = 32'h0, fl_a = 32'h0, fl_b = 32'h0;
	logic [23:0] op_disp = 24'h0, op_abs = 24'h0, op_len = 24'h2, mem_addr, pc_out, p;
	logic [15:0] copy_count_word = 16'h0, copy_source_ptr = 16'h0, copy_dest_ptr = 16'h0;
	logic [3:0]  ack_dly = 4'h0;
	logic        op_ready, op_done, reg_byte_we, wide_ptr_we, copy_wb, power_down;
	logic        mem_req, mem_we, mem_byte, mem_ack;
	logic [7:0]  flag_register, reg_byte_out;
	logic [31:0] stack_pointer, wide_ptr_out;
	logic [15:0] copy_count_out, copy_src_out, copy_dst_out, mem_wdata, mem_rdata;
	int          miscompares = 0, num_checks = 0, cyc, tick = 0;

	always #10 sys_clk = ~sys_clk;
	fcx_exec_core DUT (.*);
	fcx_mem_model MEM (.*);

	task wrap_up;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	always @(posedge sys_clk) begin
		tick++;
		if (tick == 3000) begin
			miscompares++;
			wrap_up();
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask

	// Cycle count runs from the accept edge (1) to the edge raising op_done.
	task run(input fcx_pkg::fcx_op_t c, input fcx_pkg::fcx_mode_t m);
		op_code = c;
		op_mode = m;
		op_valid = 1'b1;
		@(posedge sys_clk);
		#1 op_valid = 1'b0;
		cyc = 1;
		while (op_done !== 1'b1 && cyc < 300) begin
			@(posedge sys_clk);
			#1 cyc++;
		end
	endtask

	task t_flags;
		op_imm = 8'h5a;
		run(fcx_pkg::OP_LOAD_FLAGS, fcx_pkg::MODE_IMM);
		chk(flag_register, 8'h5a, "load imm");
		op_imm = 8'h3c;
		run(fcx_pkg::OP_FLAG_AND_IMM, fcx_pkg::MODE_IMM);
		chk(flag_register, 8'h18, "and imm");
		chk(cyc, 2, "and states");
		run(fcx_pkg::OP_FLAG_OR_IMM, fcx_pkg::MODE_IMM);
		chk(flag_register, 8'h3c, "or imm");
		op_imm = 8'ha5;
		run(fcx_pkg::OP_FLAG_XOR_IMM, fcx_pkg::MODE_IMM);
		chk(flag_register, 8'h99, "xor imm");
		op_imm = 8'h04;
		run(fcx_pkg::OP_LOAD_FLAGS, fcx_pkg::MODE_IMM);
		fl_valid = 1'b1;
		@(posedge sys_clk);
		#1 fl_valid = 1'b0;
		@(posedge sys_clk);
		#1 chk(flag_register[2], 1'b0, "sticky zero");
		fl_kind = fcx_pkg::FK_HALF_WORD;
		fl_a = 32'h800;
		fl_b = 32'h800;
		fl_valid = 1'b1;
		@(posedge sys_clk);
		#1 fl_valid = 1'b0;
		chk(flag_register[5], 1'b1, "half carry");
		$display("t_flags finished");
	endtask

	task t_store;
		f = flag_register;
		run(fcx_pkg::OP_STORE_FLAGS, fcx_pkg::MODE_REG);
		chk(reg_byte_out, f, "store reg");
		chk(reg_byte_we, 1'b1, "store strobe");
		chk(flag_register, f, "flags kept");
		op_ptr = 32'h40;
		run(fcx_pkg::OP_STORE_FLAGS, fcx_pkg::MODE_AUTO);
		chk(MEM.mem[8'h3f], f, "store predec");
		chk(wide_ptr_out, 32'h3e, "predec ptr");
		MEM.mem[8'h41] = 8'h0f;
		run(fcx_pkg::OP_LOAD_FLAGS, fcx_pkg::MODE_AUTO);
		chk(flag_register, 8'h0f, "load postinc");
		chk(wide_ptr_out, 32'h42, "postinc ptr");
		MEM.mem[8'h51] = 8'h33;
		op_abs = 24'h50;
		run(fcx_pkg::OP_LOAD_FLAGS, fcx_pkg::MODE_ABS);
		chk(flag_register, 8'h33, "load abs");
		$display("t_store finished");
	endtask

	task t_return;
		sp_value = 32'h20;
		sp_load = 1'b1;
		@(posedge sys_clk);
		#1 sp_load = 1'b0;
		MEM.mem[8'h21] = 8'h8b;
		MEM.mem[8'h22] = 8'h12;
		MEM.mem[8'h23] = 8'h34;
		run(fcx_pkg::OP_EXCEPTION_RETURN, fcx_pkg::MODE_IMM);
		chk(flag_register, 8'h8b, "popped flags");
		chk(pc_out, 24'h1234, "popped pc");
		chk(stack_pointer, 32'h24, "sp after pops");
		$display("t_return finished");
	endtask

	task t_copy;
		for (int i = 0; i < 3; i++)
			MEM.mem[8'h80 + i] = 8'h11 * (i + 1);
		copy_source_ptr = 16'h80;
		copy_dest_ptr = 16'ha0;
		copy_count_word = 16'h3;
		run(fcx_pkg::OP_BLOCK_COPY_WORD, fcx_pkg::MODE_IMM);
		chk(cyc, 20, "copy states");
		chk(copy_wb, 1'b1, "copy strobe");
		chk(copy_count_out, 16'h0, "word count");
		chk(copy_src_out, 16'h83, "src ptr");
		for (int i = 0; i < 3; i++)
			chk(MEM.mem[8'ha0 + i], 8'h11 * (i + 1), "copied byte");
		copy_count_word = 16'h0101;
		copy_dest_ptr = 16'hc0;
		run(fcx_pkg::OP_BLOCK_COPY_BYTE, fcx_pkg::MODE_IMM);
		chk(cyc, 12, "byte count states");
		chk(copy_dst_out, 16'hc1, "byte count dst");
		copy_count_word = 16'h0;
		run(fcx_pkg::OP_BLOCK_COPY_WORD, fcx_pkg::MODE_IMM);
		chk(cyc, 8, "zero count states");
		chk(copy_dst_out, 16'hc0, "zero count dst");
		ack_dly = 4'h3;
		copy_count_word = 16'h1;
		run(fcx_pkg::OP_BLOCK_COPY_WORD, fcx_pkg::MODE_IMM);
		chk(cyc, 18, "slow memory stretch");
		ack_dly = 4'h0;
		$display("t_copy finished");
	endtask

	task t_sleep;
		p = pc_out;
		op_code = fcx_pkg::OP_POWER_DOWN;
		op_valid = 1'b1;
		@(posedge sys_clk);
		#1 op_valid = 1'b0;
		@(posedge sys_clk);
		#1 chk(power_down, 1'b1, "asleep");
		wake_pin = 1'b1;
		repeat (3) @(posedge sys_clk);
		#1 wake_pin = 1'b0;
		chk(op_done, 1'b1, "woken");
		chk(power_down, 1'b0, "awake");
		chk(pc_out, p + 24'h2, "sleep pc");
		$display("t_sleep finished");
	endtask

	task t_nop;
		p = pc_out;
		op_len = 24'h6;
		run(fcx_pkg::OP_NO_OPERATION, fcx_pkg::MODE_IMM);
		op_len = 24'h2;
		chk(pc_out, p + 24'h2, "nop pc");
		chk(cyc, 2, "nop states");
		$display("t_nop finished");
	endtask

	initial begin
		repeat (3) @(posedge sys_clk);
		#1 rst = 1'b0;
		chk(flag_register, fcx_pkg::FLAG_RESET, "reset flags");
		t_flags();
		t_store();
		t_return();
		t_copy();
		t_sleep();
		t_nop();
		wrap_up();
	end
endmodule
